// ### hw/uiorb_regs.sv
// Purpose: register blocks of eight serial channels in I/O mode
// Assumes: host base decode done outside, io_sel_in marks the window
// Notes: engines run on clk_in; their inputs need no synchroniser
`timescale 1ns/1ps

// Operation
// - eight private bytes per channel
// - channel n sits at window plus 8n
// - control and status at bytes 3 to 7
// - byte 0 read returns received character
// - byte 0 write loads transmit character
// - divisor select maps divisors, sample clock
// - enable bits 0-3 gate classic sources
// - enable bit 4 gates xoff/special detect
// - enable bit 5 gates rts/dtr change
// - enable bit 6 gates cts/dsr change
// - status reads C1 when idle
// - status encodes highest pending enabled source
// - line control bit 7 selects divisors
// - fifo control write, flush bits self-clear
module uiorb_regs (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic io_sel_in,
  input wire logic [7:0] io_addr_in,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  output logic io_rvalid_out,
  output logic io_ready_out,
  input wire logic rx_valid_in,
  input wire logic [2:0] rx_chan_in,
  input wire logic [7:0] rx_data_in,
  input wire logic [7:0] rx_error_in,
  input wire logic [7:0] rx_timeout_in,
  input wire logic [7:0] tx_empty_in,
  input wire logic [7:0] modem_change_in,
  input wire logic [7:0] xoff_detect_in,
  input wire logic [7:0] rts_dtr_change_in,
  input wire logic [7:0] cts_dsr_change_in,
  input wire logic [63:0] line_status_in,
  input wire logic [63:0] modem_status_in,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic [2:0] tx_chan_out,
  output logic [7:0] tx_data_out,
  output logic [7:0] irq_out,
  output logic [63:0] line_control_out,
  output logic [63:0] modem_control_out,
  output logic [63:0] special_function_out,
  output logic [127:0] baud_divisor_out,
  output logic [63:0] sample_clock_out,
  output logic [63:0] fifo_control_out,
  output logic [7:0] rx_flush_out,
  output logic [7:0] tx_flush_out
);
  import uiorb_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0][7:0] rx_hold, tx_hold, irq_en, div_lo, div_hi;
    logic [7:0][7:0] sample, line_ctl, modem_ctl, special, fifo_ctl;
    logic [7:0] rx_avail, irq, rx_flush, tx_flush;
    logic [7:0] rdata;
    logic rvalid;
    logic ready;
    logic [1:0] tb_v;
    // entries are {channel, data}; the head always sits in entry 0
    logic [1:0][10:0] tb;
  } uiorb_state_s;

  function automatic uiorb_state_s rst_state();
    uiorb_state_s r;
    r = '0;
    for (int c = 0; c < CH_NUM; c++) begin
      r.rx_hold[c] = RST_RX_HOLD;
      r.tx_hold[c] = RST_TX_HOLD;
      r.irq_en[c] = RST_IRQ_EN;
      r.div_lo[c] = RST_DIV_LOW;
      r.div_hi[c] = RST_DIV_HIGH;
      r.sample[c] = RST_SAMPLE;
      r.line_ctl[c] = RST_LINE_CTL;
      r.modem_ctl[c] = RST_MODEM_CTL;
      r.special[c] = RST_SPECIAL;
      r.fifo_ctl[c] = RST_FIFO_CTL;
    end
    r.rdata = RST_RDATA;
    r.ready = 1'b1;
    return r;
  endfunction

  localparam uiorb_state_s RST_STATE = rst_state();

  // ----------------------------------------------------------------
  // interrupt priority encoder
  // ----------------------------------------------------------------
  // src: 0 rx err, 1 rx data, 2 rx timeout, 3 tx empty, 4 modem,
  // 5 xoff/special, 6 rts/dtr change, 7 cts/dsr change
  function automatic logic [7:0] irq_code(
    input logic [7:0] en,
    input logic [7:0] src
  );
    logic [7:0] g;
    logic [7:0] code;
    g[0] = src[0] & en[IE_RX_LINE];
    g[1] = src[1] & en[IE_RX_DATA];
    // timeout has no enable of its own and rides on data ready
    g[2] = src[2] & en[IE_RX_DATA];
    g[3] = src[3] & en[IE_TX_EMPTY];
    g[4] = src[4] & en[IE_MODEM];
    g[5] = src[5] & en[IE_XOFF];
    g[6] = src[6] & en[IE_RTS_DTR];
    g[7] = src[7] & en[IE_CTS_DSR];
    if (g[0]) begin
      code = {ST_TOP, ST_RX_ERR};
    end else if (g[1]) begin
      code = {ST_TOP, ST_RX_DATA};
    end else if (g[2]) begin
      code = {ST_TOP, ST_RX_TMO};
    end else if (g[3]) begin
      code = {ST_TOP, ST_TX_EMPTY};
    end else if (g[4]) begin
      code = {ST_TOP, ST_MODEM};
    end else if (g[5]) begin
      code = {ST_TOP, ST_XOFF};
    end else if (g[6] | g[7]) begin
      code = {ST_TOP, ST_FLOW};
    end else begin
      code = ST_NONE;
    end
    return code;
  endfunction

  // one channel's byte out of a bus that carries a byte per channel
  function automatic logic [7:0] chan_byte(
    input logic [63:0] bus,
    input logic [2:0] c
  );
    return bus[{c, 3'h0} +: 8];
  endfunction

  uiorb_state_s s_q;
  uiorb_state_s s_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0][7:0] code;
    logic [7:0] src;
    logic [2:0] ch;
    logic [2:0] ofs;
    logic hit;
    logic div;
    logic rd;
    logic wr;
    code = '0;
    src = '0;
    s_d = s_q;
    // only bytes 00..3F of the window are decoded
    hit = io_sel_in & s_q.ready & (io_addr_in <= WINDOW_LAST);
    // low three bits pick the byte in a block
    ofs = io_addr_in[2:0];
    // next three bits pick the channel
    ch = io_addr_in[5:3];
    div = s_q.line_ctl[ch][LC_DIV_SEL];
    rd = hit & io_rd_in;
    wr = hit & io_wr_in;

    for (int c = 0; c < CH_NUM; c++) begin
      src = {cts_dsr_change_in[c], rts_dtr_change_in[c],
             xoff_detect_in[c], modem_change_in[c], tx_empty_in[c],
             rx_timeout_in[c], s_q.rx_avail[c], rx_error_in[c]};
      code[c] = irq_code(s_q.irq_en[c], src);
      // request while any enabled source pends
      s_d.irq[c] = ~code[c][0];
      // flush bits clear themselves after one cycle
      s_d.fifo_ctl[c][FC_RX_FLUSH] = 1'b0;
      s_d.fifo_ctl[c][FC_TX_FLUSH] = 1'b0;
    end
    s_d.rx_flush = '0;
    s_d.tx_flush = '0;

    // tx buffer drain: the head always sits in entry 0
    if (s_q.tb_v[0] & tx_ready_in) begin
      s_d.tb[0] = s_q.tb[1];
      s_d.tb_v = {1'b0, s_q.tb_v[1]};
    end

    // read path; answer lands one cycle after the request
    // reads beyond 3F get no answer; the host must not wait for one
    s_d.rvalid = hit & io_rd_in;
    s_d.rdata = RST_RDATA;
    if (rd) begin
      case (ofs)
        OFS_HOLD: begin
          if (div) begin
            s_d.rdata = s_q.div_lo[ch];
          end else begin
            s_d.rdata = s_q.rx_hold[ch];
            s_d.rx_avail[ch] = 1'b0;
          end
        end
        OFS_IRQ_EN: begin
          s_d.rdata = div ? s_q.div_hi[ch] : s_q.irq_en[ch];
        end
        OFS_IRQ_ST: begin
          // status read, or sample clock when divisors are selected; never the fifo control value
          s_d.rdata = div ? s_q.sample[ch] : code[ch];
        end
        OFS_LINE_CTL: begin
          s_d.rdata = s_q.line_ctl[ch];
        end
        OFS_MODEM_CTL: begin
          s_d.rdata = s_q.modem_ctl[ch];
        end
        OFS_LINE_ST: begin
          s_d.rdata = chan_byte(line_status_in, ch);
        end
        OFS_MODEM_ST: begin
          s_d.rdata = chan_byte(modem_status_in, ch);
        end
        OFS_SPECIAL: begin
          s_d.rdata = s_q.special[ch];
        end
        default: begin
          s_d.rdata = RST_RDATA;
        end
      endcase
    end

    // write path
    if (wr) begin
      case (ofs)
        OFS_HOLD: begin
          if (div) begin
            s_d.div_lo[ch] = io_wdata_in;
          end else begin
            // transmit character into the buffer
            // tx_hold is only the register image; the buffer carries it
            s_d.tx_hold[ch] = io_wdata_in;
            if (!s_d.tb_v[0]) begin
              s_d.tb[0] = {ch, io_wdata_in};
              s_d.tb_v[0] = 1'b1;
            end else begin
              s_d.tb[1] = {ch, io_wdata_in};
              s_d.tb_v[1] = 1'b1;
            end
          end
        end
        OFS_IRQ_EN: begin
          if (div) begin
            s_d.div_hi[ch] = io_wdata_in;
          end else begin
            // bit 7 kept as plain storage
            s_d.irq_en[ch] = io_wdata_in;
          end
        end
        OFS_IRQ_ST: begin
          if (div) begin
            s_d.sample[ch] = io_wdata_in;
          end else begin
            s_d.fifo_ctl[ch] = io_wdata_in;
            s_d.rx_flush[ch] = io_wdata_in[FC_RX_FLUSH];
            s_d.tx_flush[ch] = io_wdata_in[FC_TX_FLUSH];
          end
        end
        OFS_LINE_CTL: begin
          s_d.line_ctl[ch] = io_wdata_in;
        end
        OFS_MODEM_CTL: begin
          s_d.modem_ctl[ch] = io_wdata_in;
        end
        OFS_SPECIAL: begin
          s_d.special[ch] = io_wdata_in;
        end
        default: begin
          // status bytes are read-only; writes fall away
          s_d.special[ch] = s_d.special[ch];
        end
      endcase
    end

    // new character after the read clear, so an arrival wins
    if (rx_valid_in) begin
      s_d.rx_hold[rx_chan_in] = rx_data_in;
      s_d.rx_avail[rx_chan_in] = 1'b1;
    end

    // accept host accesses only while a tx slot stays free
    // trade-off: a full buffer stalls reads too, keeping one stall rule
    s_d.ready = ~s_d.tb_v[1];
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign io_rdata_out = s_q.rdata;
  assign io_rvalid_out = s_q.rvalid;
  assign io_ready_out = s_q.ready;
  assign tx_valid_out = s_q.tb_v[0];
  assign tx_chan_out = s_q.tb[0][10:8];
  assign tx_data_out = s_q.tb[0][7:0];
  assign irq_out = s_q.irq;
  assign line_control_out = s_q.line_ctl;
  assign modem_control_out = s_q.modem_ctl;
  assign special_function_out = s_q.special;
  assign sample_clock_out = s_q.sample;
  assign fifo_control_out = s_q.fifo_ctl;
  assign rx_flush_out = s_q.rx_flush;
  assign tx_flush_out = s_q.tx_flush;

  always_comb begin
    for (int c = 0; c < CH_NUM; c++) begin
      baud_divisor_out[c*16 +: 16] = {s_q.div_hi[c], s_q.div_lo[c]};
    end
  end

endmodule // uiorb_regs

// ### shared/uiorb_pkg.sv
// Purpose: constants for the eight-channel serial register block
// Assumes: byte-wide host access through the host base window
// Notes: offsets are byte offsets within one 8-byte channel block
package uiorb_pkg;

  // ----------------------------------------------------------------
  // window geometry
  // ----------------------------------------------------------------
  localparam int CH_NUM = 8;
  localparam logic [7:0] WINDOW_LAST = 8'h3F;

  // ----------------------------------------------------------------
  // offsets inside a channel block
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_HOLD = 3'h0;
  localparam logic [2:0] OFS_IRQ_EN = 3'h1;
  localparam logic [2:0] OFS_IRQ_ST = 3'h2;
  localparam logic [2:0] OFS_LINE_CTL = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
  localparam logic [2:0] OFS_LINE_ST = 3'h5;
  localparam logic [2:0] OFS_MODEM_ST = 3'h6;
  localparam logic [2:0] OFS_SPECIAL = 3'h7;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RX_HOLD = 8'h00;
  localparam logic [7:0] RST_TX_HOLD = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h00;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_SAMPLE = 8'h00;
  localparam logic [7:0] RST_LINE_CTL = 8'h03;
  localparam logic [7:0] RST_MODEM_CTL = 8'h00;
  localparam logic [7:0] RST_SPECIAL = 8'h00;
  localparam logic [7:0] RST_FIFO_CTL = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LC_DIV_SEL = 7;
  localparam int IE_RX_DATA = 0;
  localparam int IE_TX_EMPTY = 1;
  localparam int IE_RX_LINE = 2;
  localparam int IE_MODEM = 3;
  localparam int IE_XOFF = 4;
  localparam int IE_RTS_DTR = 5;
  localparam int IE_CTS_DSR = 6;
  localparam int FC_RX_FLUSH = 1;
  localparam int FC_TX_FLUSH = 2;

  // ----------------------------------------------------------------
  // interrupt status codes, bits 5..0, highest priority first
  // ----------------------------------------------------------------
  localparam logic [1:0] ST_TOP = 2'h3;
  localparam logic [5:0] ST_RX_ERR = 6'h06;
  localparam logic [5:0] ST_RX_DATA = 6'h04;
  localparam logic [5:0] ST_RX_TMO = 6'h0C;
  localparam logic [5:0] ST_TX_EMPTY = 6'h02;
  localparam logic [5:0] ST_MODEM = 6'h00;
  localparam logic [5:0] ST_XOFF = 6'h10;
  localparam logic [5:0] ST_FLOW = 6'h20;
  localparam logic [7:0] ST_NONE = 8'hC1;

endpackage

// ### tb/uiorb_regs_monitor.sv
// Purpose: port checker for the serial register block
// Assumes: sees only top-level ports; attached by bind
// Notes: enables are internal, so irq levels are judged by the bench
`timescale 1ns/1ps
module uiorb_regs_monitor (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic io_sel_in,
  input wire logic [7:0] io_addr_in,
  input wire logic io_rd_in,
  input wire logic io_wr_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic io_rvalid_out,
  input wire logic io_ready_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic [2:0] tx_chan_out,
  input wire logic [7:0] tx_data_out,
  input wire logic [7:0] rx_flush_out,
  input wire logic [7:0] tx_flush_out,
  input wire logic [63:0] line_control_out,
  input wire logic [63:0] modem_control_out,
  input wire logic [63:0] special_function_out,
  input wire logic [127:0] baud_divisor_out
);
  // ----------------------------------------------------------------
  // taken accesses
  // ----------------------------------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic wtk;
  assign wtk = io_sel_in & io_ready_out & io_wr_in & (io_addr_in < 8'h40);
  sequence s_rd;
    io_sel_in && io_ready_out && io_rd_in;
  endsequence
  // reads beyond the window are dropped without an answer
  property p_rd_ans;
    s_rd ##0 (io_addr_in <= 8'h3F) |=> io_rvalid_out;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_no_ans;
    !(io_sel_in && io_ready_out && io_rd_in && io_addr_in <= 8'h3F) |=>
      !io_rvalid_out;
  endproperty
  a_no_ans: assert property (p_no_ans) else $error("stray rvalid");
  property p_idle_data;
    !io_rvalid_out |-> io_rdata_out == 8'h00;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("rdata idle");
  property p_out_win;
    s_rd ##0 (io_addr_in > 8'h3F) |=>
      !io_rvalid_out && io_rdata_out == 8'h00;
  endproperty
  a_out_win: assert property (p_out_win) else $error("outside data");
  property p_tx_hold;
    tx_valid_out && !tx_ready_in |=>
      tx_valid_out && $stable(tx_chan_out) && $stable(tx_data_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx head lost");
  property p_full;
    !io_ready_out |-> tx_valid_out;
  endproperty
  a_full: assert property (p_full) else $error("stall without data");
  property p_rdy_back;
    !io_ready_out && tx_ready_in |=> io_ready_out;
  endproperty
  a_rdy_back: assert property (p_rdy_back) else $error("ready stuck");
  property p_lc;
    $changed(line_control_out) |-> $past(wtk && io_addr_in[2:0] == 3'h3);
  endproperty
  a_lc: assert property (p_lc) else $error("line ctl moved");
  property p_mc;
    $changed(modem_control_out) |-> $past(wtk && io_addr_in[2:0] == 3'h4);
  endproperty
  a_mc: assert property (p_mc) else $error("modem ctl moved");
  property p_sf;
    $changed(special_function_out) |->
      $past(wtk && io_addr_in[2:0] == 3'h7);
  endproperty
  a_sf: assert property (p_sf) else $error("special moved");
  property p_div;
    $changed(baud_divisor_out) |-> $past(wtk && io_addr_in[2:1] == 2'h0);
  endproperty
  a_div: assert property (p_div) else $error("divisor moved");
  property p_flush;
    (rx_flush_out != 8'h00 || tx_flush_out != 8'h00) |->
      $past(wtk && io_addr_in[2:0] == 3'h2) ||
      $past(wtk && io_addr_in[2:0] == 3'h2, 2);
  endproperty
  a_flush: assert property (p_flush) else $error("stray flush");
endmodule // uiorb_regs_monitor

bind uiorb_regs uiorb_regs_monitor u_mon (
  .clk_in, .resetn_in, .io_sel_in, .io_addr_in, .io_rd_in, .io_wr_in,
  .io_rdata_out, .io_rvalid_out, .io_ready_out, .tx_valid_out,
  .tx_ready_in, .tx_chan_out, .tx_data_out, .rx_flush_out,
  .tx_flush_out, .line_control_out, .modem_control_out,
  .special_function_out, .baud_divisor_out
);

// ### tb/uiorb_regs_tb.sv
// Purpose: self-checking bench for the serial register block
// Assumes: inputs change on the falling edge only
// Notes: table rows first, then rx, priority, tx stall and flush
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module uiorb_regs_tb;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} uiorb_row_s;
  logic clk_in = 1'b0;
  logic resetn_in, io_sel_in, io_rd_in, io_wr_in, rx_valid_in;
  logic tx_ready_in, io_rvalid_out, io_ready_out, tx_valid_out;
  logic [7:0] io_addr_in, io_wdata_in, io_rdata_out, rx_data_in, q;
  logic [7:0] tx_data_out, irq_out, rx_flush_out, tx_flush_out;
  logic [2:0] rx_chan_in, tx_chan_out;
  logic [55:0] srcv;
  logic [63:0] lstat, mstat, line_control_out, fifo_control_out;
  logic [63:0] mctl, sfun, sclk;
  logic [127:0] baud_divisor_out;
  int n_errors = 0, checked = 0, n;
  logic [7:0] codes [8] = '{8'hC6, 8'hCC, 8'hC2, 8'hC0, 8'hD0, 8'hE0,
    8'hE0, 8'hC1};
  uiorb_row_s rows [27] = '{
    '{0, 8'h02, 8'hC1}, '{0, 8'h01, 8'h00}, '{0, 8'h00, 8'h00},
    '{0, 8'h03, 8'h03}, '{1, 8'h0B, 8'h1B}, '{0, 8'h0B, 8'h1B},
    '{0, 8'h03, 8'h03}, '{1, 8'h3C, 8'h5A}, '{0, 8'h3C, 8'h5A},
    '{1, 8'h3F, 8'hA5}, '{0, 8'h3F, 8'hA5}, '{1, 8'h45, 8'h77},
    '{0, 8'h45, 8'h00}, '{1, 8'h05, 8'hFF}, '{0, 8'h05, 8'h11},
    '{0, 8'h2E, 8'hD0}, '{1, 8'h01, 8'h80}, '{0, 8'h01, 8'h80},
    '{1, 8'h03, 8'h80}, '{1, 8'h00, 8'h34}, '{1, 8'h01, 8'h12},
    '{1, 8'h02, 8'h56}, '{0, 8'h00, 8'h34}, '{0, 8'h01, 8'h12},
    '{0, 8'h02, 8'h56}, '{1, 8'h03, 8'h03}, '{0, 8'h01, 8'h80}};
  uiorb_regs dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .io_sel_in(io_sel_in),
    .io_addr_in(io_addr_in), .io_rd_in(io_rd_in), .io_wr_in(io_wr_in),
    .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
    .io_rvalid_out(io_rvalid_out), .io_ready_out(io_ready_out),
    .rx_valid_in(rx_valid_in), .rx_chan_in(rx_chan_in),
    .rx_data_in(rx_data_in), .rx_error_in(srcv[55:48]),
    .rx_timeout_in(srcv[47:40]), .tx_empty_in(srcv[39:32]),
    .modem_change_in(srcv[31:24]), .xoff_detect_in(srcv[23:16]),
    .rts_dtr_change_in(srcv[15:8]), .cts_dsr_change_in(srcv[7:0]),
    .line_status_in(lstat), .modem_status_in(mstat),
    .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
    .tx_chan_out(tx_chan_out), .tx_data_out(tx_data_out),
    .irq_out(irq_out), .line_control_out(line_control_out),
    .modem_control_out(mctl), .special_function_out(sfun),
    .baud_divisor_out(baud_divisor_out), .sample_clock_out(sclk),
    .fifo_control_out(fifo_control_out), .rx_flush_out(rx_flush_out),
    .tx_flush_out(tx_flush_out));
  always #5 clk_in = ~clk_in;
  // ----------------------------------------------------------------
  // host access tasks
  // ----------------------------------------------------------------
  task automatic acc(input logic w, input logic [7:0] a, d);
    n = 0;
    // one edge between calls, so strobes never fall and rise at once
    @(negedge clk_in);
    while (!io_ready_out && n < 50) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 50) n_errors++;
    io_sel_in = 1'b1;
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = w;
    io_rd_in = !w;
    @(negedge clk_in);
    io_sel_in = 1'b0;
    io_wr_in = 1'b0;
    io_rd_in = 1'b0;
    q = io_rdata_out;
    if (!w) `CHK(io_rvalid_out, a <= 8'h3F)
  endtask
  task automatic rd(input logic [7:0] a, e);
    acc(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {resetn_in, io_sel_in, io_rd_in, io_wr_in, rx_valid_in} = '0;
    {io_addr_in, io_wdata_in, rx_data_in, rx_chan_in, srcv} = '0;
    tx_ready_in = 1'b1;
    lstat = 64'h8877665544332211;
    mstat = 64'hF0E0D0C0B0A09080;
    repeat (6) @(negedge clk_in);
    `CHK(line_control_out, {8{8'h03}})
    resetn_in = 1'b1;
    `CHK({io_ready_out, irq_out}, 9'h100)
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK(q, rows[i].d)
    end
    `CHK(baud_divisor_out[15:0], 16'h1234)
    `CHK(sclk[7:0], 8'h56)
    `CHK(mctl[63:56], 8'h5A)
    `CHK(sfun[63:56], 8'hA5)
    {rx_chan_in, rx_data_in, rx_valid_in} = {3'h3, 8'hC3, 1'b1};
    @(negedge clk_in);
    rx_valid_in = 1'b0;
    acc(1'b1, 8'h19, 8'h01);
    repeat (2) @(negedge clk_in);
    `CHK(irq_out, 8'h08)
    rd(8'h1A, 8'hC4);
    rd(8'h18, 8'hC3);
    rd(8'h1A, 8'hC1);
    repeat (2) @(negedge clk_in);
    `CHK(irq_out, 8'h00)
    acc(1'b1, 8'h11, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      srcv = '0;
      for (int k = i; k < 7; k++) begin
        srcv[8*(6-k)+2] = 1'b1;
      end
      @(negedge clk_in);
      rd(8'h12, codes[i]);
      `CHK(irq_out[2], i < 7)
    end
    acc(1'b1, 8'h11, 8'h00);
    srcv[34] = 1'b1;
    repeat (3) @(negedge clk_in);
    `CHK(irq_out, 8'h00)
    srcv = '0;
    tx_ready_in = 1'b0;
    acc(1'b1, 8'h00, 8'h11);
    acc(1'b1, 8'h08, 8'h22);
    `CHK(io_ready_out, 1'b0)
    `CHK({tx_valid_out, tx_chan_out, tx_data_out}, 12'h811)
    tx_ready_in = 1'b1;
    @(negedge clk_in);
    `CHK({tx_valid_out, tx_chan_out, tx_data_out}, 12'h922)
    @(negedge clk_in);
    `CHK(tx_valid_out, 1'b0)
    acc(1'b1, 8'h0A, 8'h06);
    n = 0;
    repeat (3) begin
      if (rx_flush_out === 8'h02 && tx_flush_out === 8'h02) n++;
      @(negedge clk_in);
    end
    `CHK(n, 1)
    `CHK(fifo_control_out[15:8], 8'h00)
    // mid-run reset with a character and registers still loaded
    {rx_chan_in, rx_data_in, rx_valid_in} = {3'h5, 8'h5C, 1'b1};
    @(negedge clk_in);
    rx_valid_in = 1'b0;
    resetn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    `CHK(line_control_out, {8{8'h03}})
    `CHK(baud_divisor_out, 128'h0)
    `CHK({io_ready_out, tx_valid_out, irq_out}, 10'h200)
    resetn_in = 1'b1;
    rd(8'h28, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h3C, 8'h00);
    end_of_test();
  end
endmodule // uiorb_regs_tb
